// [bench/host_bus_model.sv]
// Host processor model that runs parallel bus cycles against the display port.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
	import lcd_port_pkg::*;
(
	input wire logic clock,
	output logic register_select,
	output logic read_write,
	output logic enable,
	output logic [DATA_W-1:0] data_in,
	input wire logic [DATA_W-1:0] data_out_q,
	input wire logic data_oe_n_q
);
	logic drive;
	logic [DATA_W-1:0] host_val;
	// A released bus shows the inverse of the last byte, so stale data never reads as good.
	assign data_in = !data_oe_n_q ? data_out_q : (drive ? host_val : ~host_val);
	initial begin
		register_select = 1'b0;
		read_write = 1'b1;
		enable = 1'b0;
		drive = 1'b0;
		host_val = 8'h00;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Strobe high and low phases last six clocks, above the synchroniser minimum.
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] w, output logic [7:0] r);
		step(1);
		register_select = rs;
		read_write = rw;
		host_val = w;
		drive = !rw;
		step(1);
		enable = 1'b1;
		step(6);
		r = data_in;
		enable = 1'b0;
		step(6);
		drive = 1'b0;
		read_write = 1'b1;
	endtask
	// Polls status until the busy bit drops, then leaves a spare cycle.
	task automatic wait_ready(output logic ok);
		logic [7:0] st;
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			xfer(1'b0, 1'b1, 8'h00, st);
			ok = (st[7] === 1'b0);
		end
		step(1);
	endtask
endmodule
`default_nettype wire

// [bench/lcd_host_port_display_data_memory_map_test.sv]
// Self-checking bench for the display host port and memory map.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_port_display_data_memory_map_test
	import lcd_port_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n, interface_mode_select, register_select, read_write, enable;
	logic extension_enable, bus_four_bit, font_wide, ac_decrement, address_load;
	logic shift_pulse, shift_right, instruction_strobe_q, busy_flag, data_oe_n_q, scan_valid_q;
	logic [1:0] line_mode;
	logic [3:0] shift_line_mask;
	logic [5:0] scan_common;
	logic [6:0] address_value, scan_position, display_address_counter, visible_chars_q;
	logic [6:0] scan_address_q;
	logic [7:0] data_in, data_out_q, instruction_holding_register, data_holding_register;
	logic [7:0] scan_char_q, rd;
	int errors, cmp_count;
	int strobes = 0;
	localparam logic [6:0] VIS [12] = '{7'h18, 7'h18, 7'h0c, 7'h20, 7'h20, 7'h14,
		7'h14, 7'h14, 7'h0a, 7'h1a, 7'h1a, 7'h10};
	always #2.5 clock = ~clock;
	always @(posedge clock) if (instruction_strobe_q === 1'b1) strobes <= strobes + 1;
	// Short busy counts keep the run brief; forty still outlasts one bus cycle.
	lcd_host_port_display_data_memory_map #(.INSTR_CYCLES(40), .DATA_CYCLES(4)) DUT (.clock(clock),
		.rst_n(rst_n), .interface_mode_select(interface_mode_select),
		.register_select(register_select), .read_write(read_write), .enable(enable),
		.data_in(data_in), .data_out_q(data_out_q), .data_oe_n_q(data_oe_n_q),
		.extension_enable(extension_enable), .bus_four_bit(bus_four_bit),
		.line_mode(line_mode), .font_wide(font_wide), .ac_decrement(ac_decrement),
		.address_load(address_load), .address_value(address_value),
		.shift_pulse(shift_pulse), .shift_right(shift_right),
		.shift_line_mask(shift_line_mask), .scan_common(scan_common),
		.scan_position(scan_position),
		.instruction_holding_register(instruction_holding_register),
		.instruction_strobe_q(instruction_strobe_q), .busy_flag(busy_flag),
		.display_address_counter(display_address_counter),
		.data_holding_register(data_holding_register), .visible_chars_q(visible_chars_q),
		.scan_address_q(scan_address_q), .scan_valid_q(scan_valid_q),
		.scan_char_q(scan_char_q));
	host_bus_model host (.clock(clock), .register_select(register_select),
		.read_write(read_write), .enable(enable), .data_in(data_in),
		.data_out_q(data_out_q), .data_oe_n_q(data_oe_n_q));
	task automatic wrap_up();
		if (errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic instr(input logic [7:0] v, input logic [7:0] n, input logic [7:0] ir);
		int s0;
		logic [7:0] r;
		s0 = strobes;
		host.xfer(1'b0, 1'b0, v, r);
		check("strobes", n, 8'(strobes - s0));
		check("instruction reg", ir, instruction_holding_register);
	endtask
	// Four-bit transfers: high nibble first, both halves on the upper four lines.
	task automatic xfer4(input logic rs, input logic rw, input logic [7:0] w,
		output logic [7:0] r);
		logic [7:0] hi, lo;
		host.xfer(rs, rw, {w[7:4], 4'h0}, hi);
		host.xfer(rs, rw, {w[3:0], 4'h0}, lo);
		r = {hi[7:4], lo[7:4]};
	endtask
	task automatic ready();
		logic ok;
		host.wait_ready(ok);
		if (!ok) begin
			errors++;
			$display("[ERR] busy wait expected 0 seen 1");
			wrap_up();
		end
	endtask
	task automatic load(input logic [6:0] a);
		address_value = a;
		address_load = 1'b1;
		host.step(1);
		address_load = 1'b0;
		host.step(4);
	endtask
	task automatic scan(input logic [5:0] c, input logic [6:0] p, input logic [6:0] a);
		scan_common = c;
		scan_position = p;
		host.step(3);
		check("scan address", {1'b0, a}, {1'b0, scan_address_q});
		check("scan valid", 8'h01, {7'h00, scan_valid_q});
	endtask
	task automatic shift(input logic dir, input logic [3:0] mask);
		shift_right = dir;
		shift_line_mask = mask;
		shift_pulse = 1'b1;
		host.step(1);
		shift_pulse = 1'b0;
		host.step(2);
	endtask
	initial begin
		errors = 0; cmp_count = 0; rst_n = 1'b0; interface_mode_select = 1'b1;
		extension_enable = 1'b0; bus_four_bit = 1'b0; line_mode = 2'h0; font_wide = 1'b0;
		ac_decrement = 1'b0; address_load = 1'b0; address_value = 7'h00; shift_pulse = 1'b0;
		shift_right = 1'b0; shift_line_mask = 4'h0; scan_common = 6'h00; scan_position = 7'h00;
		repeat (10) @(posedge clock);
		#1 rst_n = 1'b1;
		host.step(6);
		check("counter", 8'h00, {1'b0, display_address_counter});
		check("bus enable", 8'h01, {7'h00, data_oe_n_q});
		instr(8'h38, 8'h01, 8'h38);
		host.xfer(1'b0, 1'b1, 8'h00, rd);
		check("status busy", 8'h80, rd);
		instr(8'h0c, 8'h00, 8'h38);
		ready();
		instr(8'h0c, 8'h01, 8'h0c);
		ready();
		interface_mode_select = 1'b0;
		host.step(6);
		instr(8'h01, 8'h00, 8'h0c);
		interface_mode_select = 1'b1;
		host.step(6);
		load(7'h00);
		for (int i = 0; i < 4; i++) host.xfer(1'b1, 1'b0, 8'h30 + 8'(i), rd);
		check("counter", 8'h04, {1'b0, display_address_counter});
		load(7'h4f);
		host.xfer(1'b1, 1'b0, 8'h7e, rd);
		host.xfer(1'b0, 1'b1, 8'h00, rd);
		check("status", 8'h50, rd);
		load(7'h00);
		for (int i = 0; i < 4; i++) begin
			host.xfer(1'b1, 1'b1, 8'h00, rd);
			check("read data", 8'h30 + 8'(i), rd);
		end
		ac_decrement = 1'b1;
		load(7'h03);
		host.xfer(1'b1, 1'b1, 8'h00, rd);
		check("read data", 8'h33, rd);
		check("counter", 8'h02, {1'b0, display_address_counter});
		ac_decrement = 1'b0;
		load(7'h4f);
		host.xfer(1'b1, 1'b1, 8'h00, rd);
		check("read data", 8'h7e, rd);
		host.xfer(1'b1, 1'b1, 8'h00, rd);
		check("unmapped read", 8'h00, rd);
		for (int k = 0; k < 12; k++) begin
			font_wide = (k >= 6);
			extension_enable = ((k % 6) >= 3);
			line_mode = 2'(k % 3);
			host.step(8);
			check("visible chars", {1'b0, VIS[k]}, {1'b0, visible_chars_q});
		end
		font_wide = 1'b0;
		host.step(8);
		scan(6'h01, 7'h13, 7'h13);
		extension_enable = 1'b0;
		line_mode = 2'h0;
		scan(6'h01, 7'h00, 7'h00);
		check("scan char", 8'h30, scan_char_q);
		scan(6'h01, 7'h17, 7'h17);
		line_mode = 2'h1;
		scan(6'h11, 7'h00, 7'h40);
		scan(6'h01, 7'h17, 7'h17);
		line_mode = 2'h2;
		scan(6'h19, 7'h00, 7'h60);
		scan(6'h09, 7'h0b, 7'h2b);
		scan(6'h11, 7'h00, 7'h40);
		load(7'h22);
		shift(1'b0, 4'hf);
		scan(6'h01, 7'h00, 7'h01);
		scan(6'h19, 7'h00, 7'h61);
		shift(1'b1, 4'hf);
		shift(1'b1, 4'hf);
		scan(6'h01, 7'h00, 7'h13);
		scan(6'h09, 7'h00, 7'h33);
		check("counter", 8'h22, {1'b0, display_address_counter});
		rst_n = 1'b0;
		host.step(10);
		rst_n = 1'b1;
		line_mode = 2'h1;
		host.step(6);
		check("counter", 8'h00, {1'b0, display_address_counter});
		shift(1'b1, 4'h3);
		scan(6'h01, 7'h00, 7'h27);
		scan(6'h11, 7'h00, 7'h67);
		scan(6'h01, 7'h01, 7'h00);
		scan_position = 7'h18;
		host.step(3);
		check("scan valid", 8'h00, {7'h00, scan_valid_q});
		bus_four_bit = 1'b1;
		load(7'h40);
		xfer4(1'b1, 1'b0, 8'ha5, rd);
		check("counter", 8'h41, {1'b0, display_address_counter});
		check("data reg", 8'ha5, data_holding_register);
		load(7'h40);
		check("data reg", 8'ha5, data_holding_register);
		xfer4(1'b1, 1'b1, 8'h00, rd);
		check("read data", 8'ha5, rd);
		xfer4(1'b0, 1'b1, 8'h00, rd);
		check("status", 8'h41, rd);
		check("busy", 8'h00, {7'h00, busy_flag});
		xfer4(1'b0, 1'b0, 8'h28, rd);
		check("instruction reg", 8'h28, instruction_holding_register);
		check("busy", 8'h01, {7'h00, busy_flag});
		wrap_up();
	end
endmodule
`default_nettype wire

// [hw/display_data_memory.sv]
// Display character memory with one write port and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module display_data_memory #(
	parameter int DEPTH = 80,
	parameter int WIDTH = 8,
	parameter int IW = 7
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [IW-1:0] wr_index,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [IW-1:0] a_index,
	output logic [WIDTH-1:0] a_data_q,
	input wire logic [IW-1:0] b_index,
	output logic [WIDTH-1:0] b_data_q
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	wire a_in = int'(a_index) < DEPTH;
	wire b_in = int'(b_index) < DEPTH;

	// Contents are not reset; software fills the memory after power up.
	always_ff @(posedge clock) begin
		if (wr_en && int'(wr_index) < DEPTH) begin
			mem_q[wr_index] <= wr_data;
		end
	end

	always_ff @(posedge clock) begin
		a_data_q <= a_in ? mem_q[a_index] : '0;
		b_data_q <= b_in ? mem_q[b_index] : '0;
	end
endmodule
`default_nettype wire

// [hw/lcd_host_port_display_data_memory_map.sv]
// Parallel host port, busy flag, address counter and display memory map.
// Behaviour
// - RS low, write: store instruction code.
// - RS low, read: busy on bit7, counter below.
// - RS high: write fills data, read returns it.
// - Busy held during operations; instructions refused.
// - Eighty byte display memory.
// - Seven bit address counter, bit6 most significant.
// - One-line addresses 0x00 to 0x4f.
// - Two-line ranges 0x00-0x27 and 0x40-0x67.
// - Four-line ranges at 0x00,0x20,0x40,0x60, twenty each.
// - Unshifted positions count up from line base.
// - Four-line rows on groups of eight commons.
// - Left shift shows one address higher.
// - Four-line right shift wraps last address first.
// - Two-line right shift wraps last address first.
// - Narrow font: 24 chars, 12 in four-line.
// - Wide font: 20 chars, 10 in four-line.
// - Extension enable adds continuing positions.
// - Extension columns continue past own sixty segments.
// - Counter steps by one after memory access.
// - Read prefetches next byte; write stores byte.
// - Mode select low serial, high parallel.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_port_display_data_memory_map
	import lcd_port_pkg::*;
#(
	parameter int INSTR_CYCLES = INSTR_BUSY_CYCLES,
	parameter int DATA_CYCLES = DATA_BUSY_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic interface_mode_select,
	input wire logic register_select,
	input wire logic read_write,
	input wire logic enable,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out_q,
	output logic data_oe_n_q,
	input wire logic extension_enable,
	input wire logic bus_four_bit,
	input wire logic [1:0] line_mode,
	input wire logic font_wide,
	input wire logic ac_decrement,
	input wire logic address_load,
	input wire logic [ADDR_W-1:0] address_value,
	input wire logic shift_pulse,
	input wire logic shift_right,
	input wire logic [3:0] shift_line_mask,
	input wire logic [5:0] scan_common,
	input wire logic [6:0] scan_position,
	output logic [DATA_W-1:0] instruction_holding_register,
	output logic instruction_strobe_q,
	output logic busy_flag,
	output logic [ADDR_W-1:0] display_address_counter,
	output logic [DATA_W-1:0] data_holding_register,
	output logic [6:0] visible_chars_q,
	output logic [ADDR_W-1:0] scan_address_q,
	output logic scan_valid_q,
	output logic [DATA_W-1:0] scan_char_q
);
	// Memory index of a display address, with a flag for addresses outside every line.
	function automatic logic [7:0] map_index(input logic [1:0] mode, input logic [6:0] addr);
		logic [6:0] idx;
		logic ok;
		idx = 7'h00;
		ok = 1'b0;
		case (mode)
			LINES_ONE: begin
				idx = addr;
				ok = addr <= ONE_LINE_LAST;
			end
			LINES_TWO: begin
				idx = addr[6] ? 7'(addr[5:0] + LINE_LEN_TWO) : 7'(addr[5:0]);
				ok = addr[5:0] < 6'(LINE_LEN_TWO);
			end
			LINES_FOUR: begin
				idx = 7'(addr[4:0] + 7'(addr[6:5] * LINE_LEN_FOUR));
				ok = addr[4:0] < 5'(LINE_LEN_FOUR);
			end
			default: begin
				idx = 7'h00;
				ok = 1'b0;
			end
		endcase
		return {ok, idx};
	endfunction

	// Three stage pin synchronisers; stage one feeds only stage two.
	logic [2:0] en_s_q, rs_s_q, rw_s_q, im_s_q, ext_s_q;
	logic en_q, rs_q, rw_q, im_q, ext_q;
	always_ff @(posedge clock) begin
		en_s_q <= {en_s_q[1:0], enable};
		rs_s_q <= {rs_s_q[1:0], register_select};
		rw_s_q <= {rw_s_q[1:0], read_write};
		im_s_q <= {im_s_q[1:0], interface_mode_select};
		ext_s_q <= {ext_s_q[1:0], extension_enable};
	end
	wire en_agree = en_s_q[1] == en_s_q[2];
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			en_q <= 1'b0;
			rs_q <= 1'b0;
			rw_q <= 1'b0;
			im_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			en_q <= en_agree ? en_s_q[2] : en_q;
			rs_q <= (rs_s_q[1] == rs_s_q[2]) ? rs_s_q[2] : rs_q;
			rw_q <= (rw_s_q[1] == rw_s_q[2]) ? rw_s_q[2] : rw_q;
			im_q <= (im_s_q[1] == im_s_q[2]) ? im_s_q[2] : im_q;
			ext_q <= (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_q;
		end
	end
	// Serial mode leaves the parallel port idle and the pins undriven.
	wire parallel = im_q;
	wire en_rise = parallel && en_agree && en_s_q[2] && !en_q;
	wire en_fall = parallel && en_agree && !en_s_q[2] && en_q;

	logic [BUSY_W-1:0] busy_cnt_q;
	logic busy_q;
	logic [ADDR_W-1:0] ac_q;
	logic [DATA_W-1:0] dr_q, ir_q;
	logic nibble_q;
	logic [3:0] high_nib_q;
	logic pf1_q, pf2_q;
	logic [DATA_W-1:0] mem_a_q;

	// A byte is complete on every fall in 8-bit mode, on the second fall in 4-bit mode.
	wire byte_done = en_fall && (!bus_four_bit || nibble_q);
	wire [DATA_W-1:0] bus_byte = bus_four_bit ? {high_nib_q, data_in[7:4]} : data_in;
	wire busy_now = busy_q;
	wire instr_wr = byte_done && !rs_q && !rw_q && !busy_now;
	wire data_wr = byte_done && rs_q && !rw_q;
	wire data_rd = byte_done && rs_q && rw_q;
	wire [DATA_W-1:0] status_byte = {busy_now, ac_q};
	wire [DATA_W-1:0] read_byte = rs_q ? dr_q : status_byte;
	wire [DATA_W-1:0] read_lane = (bus_four_bit && nibble_q) ?
		{read_byte[3:0], 4'h0} : read_byte;
	wire [ADDR_W-1:0] ac_step = ac_decrement ? 7'(ac_q - 7'h01) : 7'(ac_q + 7'h01);
	wire [7:0] host_map = map_index(line_mode, ac_q);
	wire host_ok = host_map[7];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			nibble_q <= 1'b0;
			high_nib_q <= 4'h0;
		end else if (!bus_four_bit) begin
			nibble_q <= 1'b0;
		end else if (en_fall) begin
			nibble_q <= !nibble_q;
			high_nib_q <= data_in[7:4];
		end
	end

	// Busy covers instructions and data accesses, not address loads or shifts; a refused instruction does not restart it.
	// The flag is registered from the next count so the status pin never glitches.
	wire [BUSY_W-1:0] busy_cnt_d = instr_wr ? BUSY_W'(INSTR_CYCLES) :
		(data_wr || data_rd) ? BUSY_W'(DATA_CYCLES) :
		(busy_cnt_q != '0) ? BUSY_W'(busy_cnt_q - BUSY_W'(1)) : busy_cnt_q;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busy_cnt_q <= '0;
			busy_q <= 1'b0;
		end else begin
			busy_cnt_q <= busy_cnt_d;
			busy_q <= busy_cnt_d != '0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ir_q <= BYTE_RESET;
			instruction_strobe_q <= 1'b0;
		end else begin
			instruction_strobe_q <= instr_wr;
			if (instr_wr) begin
				ir_q <= bus_byte;
			end
		end
	end

	// Address loads and data accesses move the counter; shifting never does.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ac_q <= AC_RESET;
		end else if (address_load) begin
			ac_q <= address_value;
		end else if (data_wr || data_rd) begin
			ac_q <= ac_step;
		end
	end

	// After a counter move the memory needs one cycle to present the new byte.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pf1_q <= 1'b0;
			pf2_q <= 1'b0;
			dr_q <= BYTE_RESET;
		end else begin
			pf1_q <= data_rd || address_load;
			pf2_q <= pf1_q;
			if (data_wr) begin
				dr_q <= bus_byte;
			end else if (pf2_q) begin
				dr_q <= mem_a_q;
			end
		end
	end

	// Read data is launched on the rising enable and held until it falls.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			data_out_q <= BYTE_RESET;
			data_oe_n_q <= 1'b1;
		end else if (en_rise && rw_q) begin
			data_out_q <= read_lane;
			data_oe_n_q <= 1'b0;
		end else if (en_fall || !parallel) begin
			data_oe_n_q <= 1'b1;
		end
	end

	// Per-line window offsets, each kept modulo its own line length.
	logic [6:0] line_len;
	assign line_len = (line_mode == LINES_ONE) ? LINE_LEN_ONE :
		(line_mode == LINES_TWO) ? LINE_LEN_TWO : LINE_LEN_FOUR;
	logic [6:0] offset_q [4];
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_line
			wire [6:0] up = (offset_q[g] == 7'(line_len - 7'h01)) ? 7'h00 :
				7'(offset_q[g] + 7'h01);
			wire [6:0] down = (offset_q[g] == 7'h00) ? 7'(line_len - 7'h01) :
				7'(offset_q[g] - 7'h01);
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					offset_q[g] <= 7'h00;
				end else if (shift_pulse && shift_line_mask[g]) begin
					offset_q[g] <= shift_right ? down : up;
				end
			end
		end
	endgenerate

	// Visible characters: own segments per font cell, doubled when one row spans two halves.
	wire [6:0] font_w = font_wide ? FONT_WIDE : FONT_NARROW;
	wire [6:0] own_chars = 7'(OWN_SEGMENTS / font_w);
	wire [6:0] ext_chars = ext_q ? 7'(EXT_SEGMENTS / font_w) : 7'h00;
	wire [6:0] chars = 7'(((line_mode == LINES_FOUR) ? own_chars : 7'(own_chars << 1))
		+ ext_chars);

	// Scan row to text line: groups of eight commons in four-line mode.
	wire [5:0] com_m1 = 6'(scan_common - 6'h01);
	wire [1:0] scan_line = (line_mode == LINES_FOUR) ? com_m1[4:3] :
		(line_mode == LINES_TWO) ? {1'b0, com_m1[4]} : 2'b00;
	wire [7:0] pos_sum = 8'(scan_position + offset_q[scan_line]);
	wire [7:0] pos_wrap = (pos_sum >= {1'b0, line_len}) ? 8'(pos_sum - {1'b0, line_len}) :
		pos_sum;
	wire [6:0] line_base = (line_mode == LINES_FOUR) ? 7'(scan_line * LINE_STRIDE_FOUR) :
		(line_mode == LINES_TWO) ? 7'(scan_line * LINE_STRIDE_TWO) : 7'h00;
	wire [6:0] scan_addr = 7'(line_base + pos_wrap[6:0]);
	wire [7:0] scan_map = map_index(line_mode, scan_addr);
	wire scan_ok = scan_position < chars && scan_position < line_len &&
		scan_common != 6'h00 && line_mode != LINES_RSVD;

	display_data_memory #(
		.DEPTH(MEM_DEPTH),
		.WIDTH(DATA_W),
		.IW(INDEX_W)
	) u_mem (
		.clock(clock),
		.wr_en(data_wr && host_ok),
		.wr_index(host_map[6:0]),
		.wr_data(bus_byte),
		.a_index(host_ok ? host_map[6:0] : 7'h7f),
		.a_data_q(mem_a_q),
		.b_index(scan_map[7] ? scan_map[6:0] : 7'h7f),
		.b_data_q(scan_char_q)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			scan_address_q <= AC_RESET;
			scan_valid_q <= 1'b0;
			visible_chars_q <= 7'h00;
		end else begin
			scan_address_q <= scan_addr;
			scan_valid_q <= scan_ok;
			visible_chars_q <= chars;
		end
	end

	assign instruction_holding_register = ir_q;
	assign busy_flag = busy_now;
	assign display_address_counter = ac_q;
	assign data_holding_register = dr_q;

	// Checks.
	chk_instr_while_busy: assert property (@(posedge clock) disable iff (!rst_n)
		(byte_done && !rs_q && !rw_q && busy_now) |=> !instruction_strobe_q && $stable(ir_q))
		else $error("instruction taken while busy");
	chk_instr_store: assert property (@(posedge clock) disable iff (!rst_n)
		instr_wr |=> instruction_strobe_q && ir_q == $past(bus_byte) && busy_now)
		else $error("instruction not stored");
	chk_busy_length: assert property (@(posedge clock) disable iff (!rst_n)
		instr_wr |=> busy_cnt_q == BUSY_W'(INSTR_CYCLES))
		else $error("busy count wrong");
	chk_status_byte: assert property (@(posedge clock) disable iff (!rst_n)
		(en_rise && rw_q && !rs_q && !bus_four_bit) |=>
		!data_oe_n_q && data_out_q == {$past(busy_now), $past(ac_q)})
		else $error("status byte wrong");
	chk_ac_step: assert property (@(posedge clock) disable iff (!rst_n)
		(data_wr && !address_load && !ac_decrement) |=> ac_q == 7'($past(ac_q) + 7'h01))
		else $error("counter did not step");
	chk_ac_shift: assert property (@(posedge clock) disable iff (!rst_n)
		(shift_pulse && !address_load && !data_wr && !data_rd) |=> $stable(ac_q))
		else $error("shift moved counter");
	chk_prefetch: assert property (@(posedge clock) disable iff (!rst_n)
		(data_rd && !address_load) ##1 !data_wr ##1 !data_wr |=> dr_q == $past(mem_a_q))
		else $error("prefetch missed");
	chk_data_write: assert property (@(posedge clock) disable iff (!rst_n)
		data_wr |=> dr_q == $past(bus_byte))
		else $error("data byte not held");
	chk_line_range: assert property (@(posedge clock) disable iff (!rst_n)
		(line_mode == LINES_FOUR) |-> scan_addr[4:0] < 5'(LINE_LEN_FOUR))
		else $error("address left its line");
	chk_oe_serial: assert property (@(posedge clock) disable iff (!rst_n)
		!parallel |=> data_oe_n_q)
		else $error("drove bus in serial mode");
	chk_read_launch: assert property (@(posedge clock) disable iff (!rst_n)
		(en_rise && rw_q && rs_q && !bus_four_bit) |=> !data_oe_n_q && data_out_q == $past(dr_q))
		else $error("data read byte wrong");
	chk_line_base: assert property (@(posedge clock) disable iff (!rst_n)
		(line_mode == LINES_FOUR && scan_common == 6'h19 && scan_position == 7'h00 &&
		offset_q[3] == 7'h00) |=> scan_address_q == 7'(LINE_STRIDE_TWO + LINE_STRIDE_FOUR))
		else $error("fourth line base wrong");
endmodule
`default_nettype wire

// [hw/lcd_port_pkg.sv]
// Shared constants for the character display host port and display memory map.
package lcd_port_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int MEM_DEPTH = 80;
	localparam int INDEX_W = 7;
	localparam int BUSY_FLAG_BIT = 7;
	localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
	localparam logic [6:0] LINE_LEN_ONE = 7'h50;
	localparam logic [6:0] LINE_LEN_TWO = 7'h28;
	localparam logic [6:0] LINE_LEN_FOUR = 7'h14;
	localparam logic [6:0] LINE_STRIDE_TWO = 7'h40;
	localparam logic [6:0] LINE_STRIDE_FOUR = 7'h20;
	localparam logic [6:0] OWN_SEGMENTS = 7'h3c;
	localparam logic [6:0] EXT_SEGMENTS = 7'h28;
	localparam logic [6:0] FONT_NARROW = 7'h05;
	localparam logic [6:0] FONT_WIDE = 7'h06;
	localparam logic [5:0] COMMONS_PER_LINE = 6'h08;
	localparam logic [6:0] AC_RESET = 7'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int CLOCK_PERIOD_PS = 5000;
	localparam int INSTR_BUSY_NS = 1000;
	localparam int DATA_BUSY_NS = 200;
	localparam int INSTR_BUSY_CYCLES = (INSTR_BUSY_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int DATA_BUSY_CYCLES = (DATA_BUSY_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int BUSY_W = 9;
	typedef enum logic [1:0] {
		LINES_ONE,
		LINES_TWO,
		LINES_FOUR,
		LINES_RSVD
	} line_mode_t;
endpackage
